// ### lsol_ext_model.sv
// model of the external switches, sense resistors and outer regulators
`timescale 1ns/1ps

module lsol_ext_model (
  // switch side
  input  wire logic [2:0] gate_drive_on,
  input  wire logic [2:0] load_heavy,
  output logic      [2:0] oc_cmp_raw,
  // outer regulators
  input  wire logic       outer_reg_one_enable_pin,
  input  wire logic       outer_reg_two_enable_pin,
  output logic      [1:0] outer_level_above
);
  // sense current flows only through a closed switch
  assign oc_cmp_raw = gate_drive_on & load_heavy;
  // regulator output rises above its level only while enabled
  assign outer_level_above = {outer_reg_two_enable_pin,
                              outer_reg_one_enable_pin};
endmodule : lsol_ext_model

// ### lsol_pkg.sv
// constants and register map of the load switch over-current latch block
package lsol_pkg;

  localparam int unsigned CH_NUM = 3;

  // register offsets
  localparam logic [7:0] ADDR_POWER_GOOD_STATUS       = 8'h01;
  localparam logic [7:0] ADDR_OVERCURRENT_TRIP_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL_SWITCH_CONTROL  = 8'h05;
  localparam logic [7:0] ADDR_SENSE_SWITCH_CONTROL    = 8'h06;
  localparam logic [7:0] ADDR_EXTERNAL_LEVEL_THRESH   = 8'h0f;
  localparam logic [7:0] ADDR_BREAKER_GAIN_THRESHOLD  = 8'h19;
  localparam logic [7:0] ADDR_BREAKER_LATCH_DELAY     = 8'h1a;
  localparam logic [7:0] ADDR_SECOND_SWITCH_CONFIG    = 8'h1b;
  localparam logic [7:0] ADDR_SECOND_LATCH_DELAY      = 8'h1c;
  localparam logic [7:0] ADDR_THIRD_SWITCH_CONFIG     = 8'h1d;
  localparam logic [7:0] ADDR_THIRD_LATCH_DELAY       = 8'h1e;

  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;

  // sense_switch_control fields
  localparam int unsigned SSC_SD_DIS_LSB = 0;  // shutdown disable, ch0..2
  localparam int unsigned SSC_BRK_EN     = 3;  // input breaker switch enable
  localparam int unsigned SSC_SW_EN_LSB  = 3;  // switch enables ch0..2

  // channel_switch_control fields
  localparam int unsigned CSC_OUTER_ONE  = 7;  // outer_reg_one_drive_bit
  localparam int unsigned CSC_OUTER_TWO  = 6;  // outer_reg_two_drive_bit

  // power_good_status fields
  localparam int unsigned PGS_OUTER_ONE  = 4;
  localparam int unsigned PGS_OUTER_TWO  = 5;

  // switch configuration fields
  localparam int unsigned CFG_GAIN_MSB   = 7;
  localparam int unsigned CFG_GAIN_LSB   = 6;
  localparam int unsigned CFG_THR_MSB    = 4;
  localparam int unsigned CFG_THR_LSB    = 0;

  // latch-off delay: 255 steps span 330.75 ms
  localparam longint unsigned DLY_STEP_PS  = 64'd1_297_058_824;
  localparam longint unsigned CLK_PERIOD_PS = 64'd8_000;
  localparam int unsigned DLY_STEP_CYC =
    int'(DLY_STEP_PS / CLK_PERIOD_PS);
  localparam int unsigned PRE_W = 18;

endpackage : lsol_pkg

// ### lsol_top.sv
// load switch over-current latch, switch drive and outer regulator control
//
// Contract
// - breaker switch only from its enable bit
// - breaker gain from config bits 7:6
// - breaker threshold from config bits 4:0
// - threshold reached starts latch-off delay timer
// - over-current gone early resets timer silently
// - delay expiry sets trip bit, switch off
// - breaker trip pin rises with trip bit
// - trip clears only by writing one
// - shutdown disable keeps switch on after trip
// - breaker may be on, no sensing idle
// - latched channel stays off until cleared
// - second, third switches only from bits 5:4
// - no sensing on second, third when idle
// - second, third gain from own config
// - second, third have full over-current function
// - aux open-drain flag low on second/third trip
// - outer enable pins follow control bits 7:6
// - outer enables set by host or sequencer
// - outer power-good tracks level comparator
// - faults elsewhere turn both outer enables off
`timescale 1ns/1ps

module lsol_top
  import lsol_pkg::*;
#(
  parameter int unsigned STEP_CYC = DLY_STEP_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // global activate pin
  input  wire logic       active_pin,
  // analog sense side
  input  wire logic [2:0] oc_cmp_raw,
  output logic      [1:0] breaker_gain_sel,
  output logic      [4:0] breaker_trip_threshold,
  output logic            second_gain_sel,
  output logic      [4:0] second_trip_threshold,
  output logic            third_gain_sel,
  output logic      [4:0] third_trip_threshold,
  // switch drive and trip flags
  output logic      [2:0] gate_drive_on,
  output logic            breaker_trip_flag_pin,
  output logic            auxiliary_trip_flag_o,
  output logic            auxiliary_trip_flag_oe,
  // outer regulators
  input  wire logic [1:0] seq_outer_set,
  input  wire logic [1:0] seq_outer_clr,
  input  wire logic       short_fault,
  input  wire logic       hard_short_fault,
  input  wire logic       high_voltage_fault,
  input  wire logic [1:0] outer_level_above,
  output logic      [7:0] external_level_threshold,
  output logic            outer_reg_one_enable_pin,
  output logic            outer_reg_two_enable_pin
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]                     chan_sw;
    logic [7:0]                     sense_sw;
    logic [7:0]                     ext_lvl;
    logic [2:0][7:0]                cfg;
    logic [2:0][7:0]                dly;
    logic [2:0]                     trip;
    logic [1:0]                     pgood;
    logic [2:0]                     oc_meta;
    logic [2:0]                     oc_sync;
    logic [2:0][PRE_W-1:0]          pre;
    logic [2:0][7:0]                steps;
    logic [2:0]                     gate;
    logic                           aux_oe;
    logic [7:0]                     rdata;
  } lsol_state_s;

  lsol_state_s state_reg;
  lsol_state_s state_next;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);

  function automatic logic [7:0] lsol_cfg_addr(input int unsigned ch);
    lsol_cfg_addr = (ch == 0) ? ADDR_BREAKER_GAIN_THRESHOLD :
                    (ch == 1) ? ADDR_SECOND_SWITCH_CONFIG :
                                ADDR_THIRD_SWITCH_CONFIG;
  endfunction : lsol_cfg_addr

  function automatic logic [7:0] lsol_dly_addr(input int unsigned ch);
    lsol_dly_addr = (ch == 0) ? ADDR_BREAKER_LATCH_DELAY :
                    (ch == 1) ? ADDR_SECOND_LATCH_DELAY :
                                ADDR_THIRD_LATCH_DELAY;
  endfunction : lsol_dly_addr

  logic       any_fault;
  logic [2:0] trip_set;
  logic [2:0] trip_clr;
  logic [2:0] sense_ok;
  logic [2:0] sw_en;
  logic [2:0] sd_dis;
  logic       w_ocs;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    any_fault  = short_fault | hard_short_fault | high_voltage_fault;
    w_ocs      = reg_wr && (reg_addr == ADDR_OVERCURRENT_TRIP_STATUS);
    trip_clr   = w_ocs ? reg_wdata[2:0] : 3'h0;
    sw_en      = state_reg.sense_sw[SSC_SW_EN_LSB +: 3];
    sd_dis     = state_reg.sense_sw[SSC_SD_DIS_LSB +: 3];
    trip_set   = 3'h0;
    sense_ok   = 3'h0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CHANNEL_SWITCH_CONTROL: state_next.chan_sw  = reg_wdata;
        ADDR_SENSE_SWITCH_CONTROL:   state_next.sense_sw = reg_wdata;
        ADDR_EXTERNAL_LEVEL_THRESH:  state_next.ext_lvl  = reg_wdata;
        default: begin
        end
      endcase
    end

    // over-current path per channel
    state_next.oc_meta = oc_cmp_raw;
    state_next.oc_sync = state_reg.oc_meta;
    for (int i = 0; i < 3; i++) begin
      if (reg_wr && reg_addr == lsol_cfg_addr(i)) begin
        state_next.cfg[i] = reg_wdata;
      end
      if (reg_wr && reg_addr == lsol_dly_addr(i)) begin
        state_next.dly[i] = reg_wdata;
      end
      // sensing idle while activate pin low or channel tripped
      sense_ok[i] = active_pin && sw_en[i] && !state_reg.trip[i];
      if (!(sense_ok[i] && state_reg.oc_sync[i])) begin
        state_next.pre[i]   = '0;
        state_next.steps[i] = 8'h00;
      end else if (state_reg.steps[i] == state_reg.dly[i]) begin
        trip_set[i]         = 1'b1;
        state_next.pre[i]   = '0;
        state_next.steps[i] = 8'h00;
      end else if (state_reg.pre[i] == PRE_LAST) begin
        state_next.pre[i]   = '0;
        state_next.steps[i] = state_reg.steps[i] + 8'h01;
      end else begin
        state_next.pre[i]   = state_reg.pre[i] + PRE_W'(1);
      end
    end

    // set wins over clear
    state_next.trip = (state_reg.trip & ~trip_clr) | trip_set;
    // switch off on trip unless shutdown disabled
    state_next.gate = state_next.sense_sw[SSC_SW_EN_LSB +: 3]
      & ~(state_next.trip
      & ~state_next.sense_sw[SSC_SD_DIS_LSB +: 3]);
    state_next.aux_oe = state_next.trip[1] | state_next.trip[2];

    // outer regulator enables
    for (int k = 0; k < 2; k++) begin
      if (seq_outer_set[k]) begin
        state_next.chan_sw[CSC_OUTER_ONE - k] = 1'b1;
      end
      if (seq_outer_clr[k]) begin
        state_next.chan_sw[CSC_OUTER_ONE - k] = 1'b0;
      end
    end
    if (any_fault) begin
      state_next.chan_sw[CSC_OUTER_ONE] = 1'b0;
      state_next.chan_sw[CSC_OUTER_TWO] = 1'b0;
    end
    state_next.pgood = outer_level_above;

    // read data
    state_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_POWER_GOOD_STATUS: begin
          state_next.rdata[PGS_OUTER_ONE] = state_reg.pgood[0];
          state_next.rdata[PGS_OUTER_TWO] = state_reg.pgood[1];
        end
        ADDR_OVERCURRENT_TRIP_STATUS:
          state_next.rdata = {5'h00, state_reg.trip};
        ADDR_CHANNEL_SWITCH_CONTROL: state_next.rdata = state_reg.chan_sw;
        ADDR_SENSE_SWITCH_CONTROL:   state_next.rdata = state_reg.sense_sw;
        ADDR_EXTERNAL_LEVEL_THRESH:  state_next.rdata = state_reg.ext_lvl;
        ADDR_BREAKER_GAIN_THRESHOLD: state_next.rdata = state_reg.cfg[0];
        ADDR_BREAKER_LATCH_DELAY:    state_next.rdata = state_reg.dly[0];
        ADDR_SECOND_SWITCH_CONFIG:   state_next.rdata = state_reg.cfg[1];
        ADDR_SECOND_LATCH_DELAY:     state_next.rdata = state_reg.dly[1];
        ADDR_THIRD_SWITCH_CONFIG:    state_next.rdata = state_reg.cfg[2];
        ADDR_THIRD_LATCH_DELAY:      state_next.rdata = state_reg.dly[2];
        default:                     state_next.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata              = state_reg.rdata;
  assign breaker_gain_sel       = state_reg.cfg[0][CFG_GAIN_MSB:CFG_GAIN_LSB];
  assign breaker_trip_threshold = state_reg.cfg[0][CFG_THR_MSB:CFG_THR_LSB];
  assign second_gain_sel        = state_reg.cfg[1][CFG_GAIN_LSB];
  assign second_trip_threshold  = state_reg.cfg[1][CFG_THR_MSB:CFG_THR_LSB];
  assign third_gain_sel         = state_reg.cfg[2][CFG_GAIN_LSB];
  assign third_trip_threshold   = state_reg.cfg[2][CFG_THR_MSB:CFG_THR_LSB];
  assign gate_drive_on          = state_reg.gate;
  assign breaker_trip_flag_pin  = state_reg.trip[0];
  assign auxiliary_trip_flag_o  = 1'b0;
  assign auxiliary_trip_flag_oe = state_reg.aux_oe;
  assign external_level_threshold = state_reg.ext_lvl;
  assign outer_reg_one_enable_pin = state_reg.chan_sw[CSC_OUTER_ONE];
  assign outer_reg_two_enable_pin = state_reg.chan_sw[CSC_OUTER_TWO];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_oc_held;
    active_pin && state_reg.oc_sync[0] && sw_en[0] && !state_reg.trip[0];
  endsequence

  sequence s_zero_delay_oc;
    s_oc_held ##0 (state_reg.dly[0] == 8'h00) ##0
      (state_reg.steps[0] == 8'h00);
  endsequence

  a_zero_delay_trip: assert property (
    s_zero_delay_oc |=> state_reg.trip[0])
    else $error("zero delay over-current did not trip");

  a_trip_has_cause: assert property (
    $rose(state_reg.trip[1]) |->
      $past(state_reg.oc_sync[1]) && $past(active_pin))
    else $error("trip set without over-current");

  a_timer_clears: assert property (
    !state_reg.oc_sync[0] |=> state_reg.steps[0] == 8'h00
      && !state_reg.trip[0] || $past(state_reg.trip[0]))
    else $error("timer not cleared after over-current gone");

  a_trip_gate_off: assert property (
    state_reg.trip[2] && !sd_dis[2] |-> !gate_drive_on[2])
    else $error("tripped channel still driven");

  a_sd_keeps_on: assert property (
    state_reg.trip[0] && sd_dis[0] && sw_en[0] |->
      gate_drive_on[0] && breaker_trip_flag_pin)
    else $error("shutdown disable did not keep switch on");

  a_trip_sticky: assert property (
    state_reg.trip[0] && !(w_ocs && reg_wdata[0]) |=> state_reg.trip[0])
    else $error("trip bit cleared without write one");

  a_idle_no_sense: assert property (
    !active_pin |=> state_reg.steps == '0 && state_reg.pre == '0)
    else $error("timer ran with activate pin low");

  a_aux_flag_low: assert property (
    (state_reg.trip[1] || state_reg.trip[2]) |-> auxiliary_trip_flag_oe
      && !auxiliary_trip_flag_o)
    else $error("aux flag not pulled low on trip");

  a_fault_outer_off: assert property (
    any_fault |=> !outer_reg_one_enable_pin && !outer_reg_two_enable_pin)
    else $error("outer enable stayed on after fault");

  a_pgood_track: assert property (
    ##1 reg_rd && reg_addr == ADDR_POWER_GOOD_STATUS |=>
      reg_rdata[PGS_OUTER_ONE] == $past(outer_level_above[0], 2))
    else $error("power good bit does not follow comparator");

  a_pgood_two: assert property (
    ##1 reg_rd && reg_addr == ADDR_POWER_GOOD_STATUS |=>
      reg_rdata[PGS_OUTER_TWO] == $past(outer_level_above[1], 2))
    else $error("second power good bit does not follow comparator");

  sequence s_oc_counting;
    s_oc_held ##0 (state_reg.steps[0] != state_reg.dly[0]);
  endsequence

  a_prescale_step: assert property (
    s_oc_counting ##0 (state_reg.pre[0] != PRE_LAST) |=>
      state_reg.pre[0] == $past(state_reg.pre[0]) + PRE_W'(1))
    else $error("latch-off prescaler did not advance");

  a_step_advance: assert property (
    s_oc_counting ##0 (state_reg.pre[0] == PRE_LAST) |=>
      state_reg.steps[0] == $past(state_reg.steps[0]) + 8'h01)
    else $error("latch-off step count did not advance");

  a_trip_after_delay: assert property (
    $rose(state_reg.trip[0]) |->
      $past(state_reg.steps[0]) == $past(state_reg.dly[0]))
    else $error("breaker tripped before its delay ran out");

  a_second_after_delay: assert property (
    $rose(state_reg.trip[1]) |->
      $past(state_reg.steps[1]) == $past(state_reg.dly[1]))
    else $error("second switch tripped before its delay ran out");

  a_trip_set_flag: assert property (
    trip_set[0] |=> breaker_trip_flag_pin && state_reg.trip[0])
    else $error("breaker flag pin late on trip");

  a_w1c_clears: assert property (
    w_ocs && reg_wdata[0] && !trip_set[0] |=> !state_reg.trip[0])
    else $error("write one did not clear breaker trip");

  a_breaker_en_only: assert property (
    gate_drive_on[0] |-> state_reg.sense_sw[SSC_BRK_EN])
    else $error("breaker switch on without its enable bit");

  a_load_enable_only: assert property (
    (gate_drive_on[2:1] & ~sw_en[2:1]) == 2'h0)
    else $error("load switch on without its enable bit");

  a_latch_holds_off: assert property (
    (gate_drive_on & state_reg.trip & ~sd_dis) == 3'h0)
    else $error("latched channel switch still on");

  a_second_sd_on: assert property (
    state_reg.trip[1] && sd_dis[1] && sw_en[1] |-> gate_drive_on[1])
    else $error("second switch opened with shutdown disabled");

  a_idle_no_trip: assert property (
    !active_pin |=>
      !$rose(state_reg.trip[1]) && !$rose(state_reg.trip[2]))
    else $error("load switch tripped with activate pin low");

  a_aux_release: assert property (
    !state_reg.trip[1] && !state_reg.trip[2] |-> !auxiliary_trip_flag_oe)
    else $error("aux flag held low without a trip");

  a_brk_gain_map: assert property (
    reg_wr && reg_addr == ADDR_BREAKER_GAIN_THRESHOLD |=>
      breaker_gain_sel == $past(reg_wdata[CFG_GAIN_MSB:CFG_GAIN_LSB]))
    else $error("breaker gain select does not follow the write");

  a_brk_thr_map: assert property (
    reg_wr && reg_addr == ADDR_BREAKER_GAIN_THRESHOLD |=>
      breaker_trip_threshold == $past(reg_wdata[CFG_THR_MSB:CFG_THR_LSB]))
    else $error("breaker threshold does not follow the write");

  a_third_cfg_map: assert property (
    reg_wr && reg_addr == ADDR_THIRD_SWITCH_CONFIG |=>
      third_gain_sel == $past(reg_wdata[CFG_GAIN_LSB])
      && third_trip_threshold == $past(reg_wdata[CFG_THR_MSB:CFG_THR_LSB]))
    else $error("third switch config does not follow the write");

  a_outer_write: assert property (
    reg_wr && reg_addr == ADDR_CHANNEL_SWITCH_CONTROL && !any_fault
      && seq_outer_set == 2'h0 && seq_outer_clr == 2'h0 |=>
      outer_reg_one_enable_pin == $past(reg_wdata[CSC_OUTER_ONE])
      && outer_reg_two_enable_pin == $past(reg_wdata[CSC_OUTER_TWO]))
    else $error("outer enable pins do not follow the write");

  a_seq_clr_wins: assert property (
    seq_outer_clr[1] |=> !outer_reg_two_enable_pin)
    else $error("sequencer clear did not drop outer enable");

  a_seq_set_one: assert property (
    seq_outer_set[0] && !seq_outer_clr[0] && !any_fault |=>
      outer_reg_one_enable_pin)
    else $error("sequencer set did not raise outer enable");

  a_sync_chain: assert property (
    state_reg.oc_sync == $past(state_reg.oc_meta))
    else $error("comparator synchroniser skipped a stage");

endmodule : lsol_top

// ### tb_top.sv
// register-level testbench of the load switch over-current latch
`timescale 1ns/1ps

module tb_top;
  import lsol_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       active_pin = 1'b1;
  logic [2:0] load_heavy = 3'h0;
  logic [2:0] oc_cmp_raw;
  logic [2:0] gate_drive_on;
  logic [2:0] flt = 3'h0;
  logic [1:0] seq_set = 2'h0;
  logic [1:0] seq_clr = 2'h0;
  logic [1:0] lvl;
  logic       trip_pin, aux_o, aux_oe, one_pin, two_pin;
  int         err_count = 0;
  int         total_checks = 0;
  int         cyc_count = 0;

  always #4 core_clk = ~core_clk;

  lsol_top #(.STEP_CYC(4)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .active_pin(active_pin),
    .oc_cmp_raw(oc_cmp_raw), .breaker_gain_sel(),
    .breaker_trip_threshold(), .second_gain_sel(),
    .second_trip_threshold(), .third_gain_sel(), .third_trip_threshold(),
    .gate_drive_on(gate_drive_on), .breaker_trip_flag_pin(trip_pin),
    .auxiliary_trip_flag_o(aux_o), .auxiliary_trip_flag_oe(aux_oe),
    .seq_outer_set(seq_set), .seq_outer_clr(seq_clr),
    .short_fault(flt[0]), .hard_short_fault(flt[1]),
    .high_voltage_fault(flt[2]), .outer_level_above(lvl),
    .external_level_threshold(), .outer_reg_one_enable_pin(one_pin),
    .outer_reg_two_enable_pin(two_pin));

  lsol_ext_model u_ext (
    .gate_drive_on(gate_drive_on), .load_heavy(load_heavy),
    .oc_cmp_raw(oc_cmp_raw), .outer_reg_one_enable_pin(one_pin),
    .outer_reg_two_enable_pin(two_pin), .outer_level_above(lvl));

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  always @(posedge core_clk) begin
    cyc_count++;
    if (cyc_count > 5000) begin
      err_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst_b = 1'b1;
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h08);
    chk(8'(gate_drive_on), 8'h01);
    rd(8'h06, 8'h08);
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h00);
    wr(8'h19, 8'h9f);
    chk(8'(DUT.breaker_gain_sel), 8'h02);
    chk(8'(DUT.breaker_trip_threshold), 8'h1f);
    wr(8'h1b, 8'h45);
    chk(8'(DUT.second_gain_sel), 8'h01);
    chk(8'(DUT.second_trip_threshold), 8'h05);
    wr(8'h1d, 8'h4a);
    chk(8'(DUT.third_gain_sel), 8'h01);
    chk(8'(DUT.third_trip_threshold), 8'h0a);
    wr(8'h0f, 8'ha5);
    chk(DUT.external_level_threshold, 8'ha5);
    rd(8'h0f, 8'ha5);
    wr(8'h1c, 8'h03);
    rd(8'h1c, 8'h03);
    wr(8'h1c, 8'h00);
    $display("test registers done");
    // breaker trip with a delay code of one step
    wr(8'h1a, 8'h01);
    load_heavy = 3'h1;
    cyc(4);
    load_heavy = 3'h0;
    cyc(10);
    chk(8'(trip_pin), 8'h00);
    load_heavy = 3'h1;
    cyc(6);
    chk(8'(trip_pin), 8'h00);
    cyc(1);
    chk(8'(trip_pin), 8'h01);
    chk(8'(gate_drive_on), 8'h00);
    rd(8'h04, 8'h01);
    load_heavy = 3'h0;
    active_pin = 1'b0;
    cyc(3);
    chk(8'(gate_drive_on), 8'h00);
    active_pin = 1'b1;
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h01);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    chk(8'(gate_drive_on), 8'h01);
    $display("test breaker trip done");
    // shutdown disabled keeps the switch closed
    wr(8'h06, 8'h09);
    load_heavy = 3'h1;
    cyc(8);
    chk(8'(trip_pin), 8'h01);
    chk(8'(gate_drive_on), 8'h01);
    load_heavy = 3'h0;
    wr(8'h04, 8'h01);
    chk(8'(trip_pin), 8'h00);
    $display("test shutdown disable done");
    // sensing idle while the activate pin is low
    active_pin = 1'b0;
    wr(8'h06, 8'h38);
    load_heavy = 3'h7;
    cyc(12);
    rd(8'h04, 8'h00);
    chk(8'(gate_drive_on), 8'h07);
    active_pin = 1'b1;
    cyc(10);
    chk({6'h00, aux_oe, aux_o}, 8'h02);
    rd(8'h04, 8'h07);
    chk(8'(gate_drive_on), 8'h00);
    load_heavy = 3'h0;
    wr(8'h04, 8'h07);
    chk(8'(aux_oe), 8'h00);
    $display("test second and third done");
    // outer regulator enables and power good
    wr(8'h05, 8'hc0);
    chk({6'h00, one_pin, two_pin}, 8'h03);
    cyc(2);
    rd(8'h01, 8'h30);
    seq_clr = 2'h1;
    cyc(1);
    seq_clr = 2'h0;
    chk({6'h00, one_pin, two_pin}, 8'h01);
    cyc(2);
    rd(8'h01, 8'h20);
    seq_set = 2'h1;
    cyc(1);
    seq_set = 2'h0;
    chk({6'h00, one_pin, two_pin}, 8'h03);
    seq_set = 2'h2;
    seq_clr = 2'h2;
    cyc(1);
    seq_set = 2'h0;
    seq_clr = 2'h0;
    chk({6'h00, one_pin, two_pin}, 8'h02);
    for (int i = 0; i < 3; i++) begin
      flt[i] = 1'b1;
      cyc(1);
      chk({6'h00, one_pin, two_pin}, 8'h00);
      flt[i] = 1'b0;
      wr(8'h05, 8'hc0);
    end
    $display("test outer regulators done");
    // zero delay trip, then a reset drops the latch
    wr(8'h1a, 8'h00);
    load_heavy = 3'h1;
    cyc(2);
    chk(8'(trip_pin), 8'h00);
    cyc(1);
    chk(8'(trip_pin), 8'h01);
    load_heavy = 3'h0;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    chk(8'(trip_pin), 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    chk(8'(gate_drive_on), 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule : tb_top
